// file: feecs_regs.svh
// Purpose: offsets, fields, resets of the flash error config block
// Assumes: 32-bit apb, one aligned word per register
// Notes:   8-bit registers sit in the low byte
`ifndef FEECS_REGS_SVH
`define FEECS_REGS_SVH
`define FEECS_AW          12
`define FEECS_OFF_FCFG    12'h004
`define FEECS_OFF_ERCFG   12'h008
`define FEECS_OFF_ERSTAT  12'h00c
`define FEECS_OFF_FLASH_STATUS_REG   12'h010
`define FEECS_OFF_TAG     12'h014
`define FEECS_OFF_SEC     12'h018
`define FEECS_OFF_PROT    12'h01c
`define FEECS_OFF_ECCIX   12'h020
`define FEECS_OFF_ECCR    12'h024
`define FEECS_CMD_DONE_IRQ_EN_BIT    7
`define FEECS_IGNORE_SINGLE_FAULT_BIT   4
`define FEECS_FDF_BIT     1
`define FEECS_FSF_BIT     0
`define FEECS_ERCFG_MASK  8'hdf
`define FEECS_ERCFG_RST   8'h00
`define FEECS_ERS_BIT     7
`define FEECS_PGM_BIT     6
`define FEECS_PVIOL_BIT   4
`define FEECS_DF_BIT      1
`define FEECS_SF_BIT      0
`define FEECS_DONE_BIT    7
`define FEECS_FLUSH_BIT   1
`define FEECS_BUSY_BIT    0
`define FEECS_SEC_RST     8'hff
`define FEECS_PROT_RST    3'h0
`define FEECS_TAG_W       16
// allowed protection moves, bit 8*from+to
`define FEECS_PROT_ALLOW  64'hff5a3c18080c0a0f
`endif

// file: feecs_pkg.sv
// Purpose: types shared by the flash error config block
// Assumes: constants come from feecs_regs.svh
// Notes:   whole state of the top is one packed struct
`include "feecs_regs.svh"
package feecs_pkg;
  typedef enum logic [0:0] {PH_INIT, PH_RUN} feecs_phase_e;
  typedef struct packed {
    feecs_phase_e              phase;
    logic                      cmd_irq_en;
    logic                      ign_sf;
    logic                      force_df;
    logic                      force_sf;
    logic [7:0]                ercfg;
    logic                      ers_f;
    logic                      pgm_f;
    logic                      pviol_f;
    logic                      df_f;
    logic                      sf_f;
    logic [`FEECS_TAG_W-1:0]   tag;
    logic [7:0]                sec;
    logic [2:0]                prot;
    logic [2:0]                eccix;
    logic [7:0]                cap_par;
    logic                      cap_src;
    logic [22:0]               cap_addr;
    logic [3:0][15:0]          cap_data;
    logic [31:0]               prdata;
    logic                      pready;
    logic                      pslverr;
    logic                      cmd_irq;
    logic                      err_irq;
    logic                      stop_ack;
    logic [1:0]                rvalid;
    logic [1:0][63:0]          rdata;
  } feecs_state_s;
endpackage : feecs_pkg

// file: feecs_ecc_chk.sv
// Purpose: secded check and correction of one array read
// Assumes: hamming bits are chk[CW-2:0], chk[CW-1] is overall parity
// Notes:   purely combinational
`timescale 1ns/1ns
module feecs_ecc_chk #(
  parameter int DW = 64,
  parameter int CW = 8
) (
  input  wire logic [DW-1:0] data,
  input  wire logic [CW-1:0] chk,
  output logic      [DW-1:0] corr_data,
  output logic               single_err,
  output logic               double_err
);
  // codeword position of data bit i, skipping powers of two
  function automatic int dpos(input int i);
    int n;
    int r;
    n = 0;
    r = 0;
    for (int p = 3; p < 256; p++)
    begin
      if ((p & (p - 1)) != 0)
      begin
        if (n == i && r == 0)
          r = p;
        n++;
      end
    end
    return r;
  endfunction : dpos

  logic [CW-2:0] syn;
  logic          ovr;

  // syndrome names the flipped position; overall parity tells odd/even
  always_comb
  begin
    int q;
    q = 0;
    syn = chk[CW-2:0];
    for (int i = 0; i < DW; i++)
    begin
      q = dpos(i);
      for (int c = 0; c < CW - 1; c++)
        if (q[c])
          syn[c] = syn[c] ^ data[i];
    end
    ovr = ^{data, chk};
    for (int i = 0; i < DW; i++)
      corr_data[i] = data[i] ^ (syn == (CW-1)'(dpos(i)));
    single_err = ovr;
    double_err = (syn != '0) && !ovr;
  end
endmodule : feecs_ecc_chk

// file: feecs_prot_gate.sv
// Purpose: judge a requested program array protection change
// Assumes: scenarios are 3-bit codes
// Notes:   table is a constant, one bit per from/to pair
`timescale 1ns/1ns
`include "feecs_regs.svh"
module feecs_prot_gate #(
  parameter logic [63:0] ALLOW = `FEECS_PROT_ALLOW
) (
  input  wire logic [2:0] cur,
  input  wire logic [2:0] req,
  output logic            allowed
);
  // only tightening moves are marked in the table
  always_comb
  begin
    allowed = ALLOW[{cur, req}];
  end
endmodule : feecs_prot_gate

// file: feecs_top.sv
// Purpose: flash config, error flags, ecc capture, tags, protection
// Assumes: array and controller inputs are on pclk, no sync needed
// Notes:   apb answers with one wait state, read data from setup
`timescale 1ns/1ns
`include "feecs_regs.svh"
module feecs_top (
  input  wire logic                 pclk,
  input  wire logic                 presetn,
  input  wire logic                 psel,
  input  wire logic                 penable,
  input  wire logic                 pwrite,
  input  wire logic [`FEECS_AW-1:0] paddr,
  input  wire logic [31:0]          pwdata,
  input  wire logic [3:0]           pstrb,
  output logic      [31:0]          prdata,
  output logic                      pready,
  output logic                      pslverr,
  input  wire logic [7:0]           nvm_sec_byte,
  input  wire logic [2:0]           nvm_prot_init,
  input  wire logic [1:0]           rd_valid,
  input  wire logic [1:0]           rd_prog,
  input  wire logic [1:0][22:0]     rd_addr,
  input  wire logic [1:0][63:0]     rd_data,
  input  wire logic [1:0][7:0]      rd_par,
  output logic      [1:0]           rd_out_valid,
  output logic      [1:0][63:0]     rd_out_data,
  input  wire logic                 cmd_done_flag,
  input  wire logic                 mem_controller_busy,
  input  wire logic                 ee_erase_fail,
  input  wire logic                 ee_program_fail,
  input  wire logic                 ee_wr_valid,
  input  wire logic                 ee_wr_in_ee_part,
  input  wire logic                 ee_wr_in_prot_area,
  input  wire logic                 tag_inc,
  input  wire logic                 tag_dec,
  input  wire logic                 tag_clr,
  input  wire logic                 ee_op_pending,
  input  wire logic                 stop_req,
  output logic                      stop_ack,
  output logic                      cmd_irq,
  output logic                      err_irq
);
  import feecs_pkg::*;

  localparam logic [`FEECS_TAG_W-1:0] TAG_MAX = '1;

  feecs_state_s s_q;
  feecs_state_s s_d;

  logic [1:0]       p_se;
  logic [1:0]       p_de;
  logic [1:0]       d_se;
  logic [1:0]       d_de;
  logic [1:0][63:0] p_corr;
  logic [1:0][15:0] d_corr;
  logic [1:0]       se;
  logic [1:0]       de;
  logic [1:0][63:0] corr;
  logic             prot_ok;

  // each read port checks both layouts; rd_prog picks the one in use
  for (genvar g = 0; g < 2; g++)
  begin : g_port
    feecs_ecc_chk #(
      .DW (64),
      .CW (8)
    ) u_pchk (
      .data       (rd_data[g]),
      .chk        (rd_par[g]),
      .corr_data  (p_corr[g]),
      .single_err (p_se[g]),
      .double_err (p_de[g])
    );
    feecs_ecc_chk #(
      .DW (16),
      .CW (6)
    ) u_dchk (
      .data       (rd_data[g][15:0]),
      .chk        (rd_par[g][5:0]),
      .corr_data  (d_corr[g]),
      .single_err (d_se[g]),
      .double_err (d_de[g])
    );
    assign se[g]   = rd_valid[g] & (rd_prog[g] ? p_se[g] : d_se[g]);
    assign de[g]   = rd_valid[g] & (rd_prog[g] ? p_de[g] : d_de[g]);
    assign corr[g] = rd_prog[g] ? p_corr[g] : {48'h0, d_corr[g]};
  end

  feecs_prot_gate u_prot (
    .cur     (s_q.prot),
    .req     (pwdata[2:0]),
    .allowed (prot_ok)
  );

  // next state of the whole block
  always_comb
  begin
    logic       setup;
    logic       wr_go;
    logic       wstrb;
    logic       hit_d;
    logic       hit_s;
    logic       idx_d;
    logic       idx_s;
    logic       cap;
    logic       cidx;
    logic       any_rd;
    logic       set_sf;
    logic       set_df;
    logic [7:0] clr;
    logic [31:0] rdv;
    logic       err;
    setup  = 1'b0;
    wr_go  = 1'b0;
    wstrb  = 1'b0;
    hit_d  = 1'b0;
    hit_s  = 1'b0;
    idx_d  = 1'b0;
    idx_s  = 1'b0;
    cap    = 1'b0;
    cidx   = 1'b0;
    any_rd = 1'b0;
    set_sf = 1'b0;
    set_df = 1'b0;
    clr    = 8'h00;
    rdv    = 32'h0;
    err    = 1'b0;
    s_d    = s_q;

    setup = psel & ~penable;
    wr_go = psel & penable & s_q.pready & pwrite;
    wstrb = wr_go & pstrb[0];

    // reset sequence: pick up nonvolatile bytes once, after release
    if (s_q.phase == PH_INIT)
    begin
      s_d.sec   = nvm_sec_byte;
      s_d.prot  = nvm_prot_init;
      s_d.phase = PH_RUN;
    end

    // fault selection; loop runs downward so port 0 (cpu) wins between faults of one kind; a double beats a single
    for (int g = 1; g >= 0; g--)
    begin
      if (de[g])
      begin
        hit_d = 1'b1;
        idx_d = 1'(g);
      end
      if (se[g])
      begin
        hit_s = 1'b1;
        idx_s = 1'(g);
      end
    end
    any_rd = |rd_valid;
    if (hit_d)
    begin
      cap  = 1'b1;
      cidx = idx_d;
    end
    else if (hit_s && !s_q.ign_sf && !s_q.force_df)
    begin
      cap  = 1'b1;
      cidx = idx_s;
    end

    // forced faults set flags but only real ones reach the capture
    set_df = hit_d | (any_rd & s_q.force_df);
    set_sf = (hit_s & ~s_q.ign_sf) | (any_rd & s_q.force_sf);

    // capture only while both fault flags are clear
    if (cap && !s_q.sf_f && !s_q.df_f)
    begin
      s_d.cap_par  = rd_par[cidx];
      s_d.cap_src  = cidx;
      s_d.cap_addr = rd_addr[cidx];
      s_d.cap_data = rd_data[cidx];
    end

    // write-one-to-clear; a set in the same cycle wins
    if (wstrb && paddr == `FEECS_OFF_ERSTAT)
      clr = pwdata[7:0];
    s_d.ers_f   = (s_q.ers_f & ~clr[`FEECS_ERS_BIT]) | ee_erase_fail;
    s_d.pgm_f   = (s_q.pgm_f & ~clr[`FEECS_PGM_BIT]) | ee_program_fail;
    s_d.pviol_f = (s_q.pviol_f & ~clr[`FEECS_PVIOL_BIT])
                | (ee_wr_valid & ee_wr_in_ee_part
                   & ee_wr_in_prot_area);
    s_d.df_f    = (s_q.df_f & ~clr[`FEECS_DF_BIT]) | set_df;
    s_d.sf_f    = (s_q.sf_f & ~clr[`FEECS_SF_BIT]) | set_sf;

    // tag counter belongs to the memory controller, not to software
    if (tag_clr)
      s_d.tag = '0;
    else if (tag_dec && !tag_inc && s_q.tag != '0)
      s_d.tag = s_q.tag - 1'b1;
    else if (tag_inc && !tag_dec && s_q.tag != TAG_MAX)
      s_d.tag = s_q.tag + 1'b1;

    // software writes, taken at the access edge
    if (wstrb)
    begin
      unique case (paddr)
        `FEECS_OFF_FCFG:
        begin
          s_d.cmd_irq_en = pwdata[`FEECS_CMD_DONE_IRQ_EN_BIT];
          s_d.ign_sf     = pwdata[`FEECS_IGNORE_SINGLE_FAULT_BIT];
          s_d.force_df   = pwdata[`FEECS_FDF_BIT];
          s_d.force_sf   = pwdata[`FEECS_FSF_BIT];
        end
        `FEECS_OFF_ERCFG:
          s_d.ercfg = pwdata[7:0] & `FEECS_ERCFG_MASK;
        `FEECS_OFF_PROT:
          if (prot_ok && s_q.phase == PH_RUN)
            s_d.prot = pwdata[2:0];
        `FEECS_OFF_ECCIX:
          s_d.eccix = pwdata[2:0];
        default:
          s_d.eccix = s_q.eccix;
      endcase
    end

    // read mux, sampled at setup so prdata comes from a flop
    unique case (paddr)
      `FEECS_OFF_FCFG:
        rdv = {24'h0, s_q.cmd_irq_en, 2'b00, s_q.ign_sf,
               2'b00, s_q.force_df, s_q.force_sf};
      `FEECS_OFF_ERCFG:
        rdv = {24'h0, s_q.ercfg & `FEECS_ERCFG_MASK};
      `FEECS_OFF_ERSTAT:
        rdv = {24'h0, s_q.ers_f, s_q.pgm_f, 1'b0, s_q.pviol_f,
               2'b00, s_q.df_f, s_q.sf_f};
      `FEECS_OFF_FLASH_STATUS_REG:
        rdv = {24'h0, cmd_done_flag, 5'h00,
               (s_q.tag == '0) & ~mem_controller_busy,
               mem_controller_busy};
      `FEECS_OFF_TAG:
        rdv = {{(32-`FEECS_TAG_W){1'b0}}, s_q.tag};
      `FEECS_OFF_SEC:
        rdv = {24'h0, s_q.sec};
      `FEECS_OFF_PROT:
        rdv = {29'h0, s_q.prot};
      `FEECS_OFF_ECCIX:
        rdv = {29'h0, s_q.eccix};
      `FEECS_OFF_ECCR:
      begin
        unique case (s_q.eccix)
          3'h0: rdv = {16'h0, s_q.cap_par, s_q.cap_src,
                       s_q.cap_addr[22:16]};
          3'h1: rdv = {16'h0, s_q.cap_addr[15:0]};
          3'h2: rdv = {16'h0, s_q.cap_data[0]};
          3'h3: rdv = {16'h0, s_q.cap_data[1]};
          3'h4: rdv = {16'h0, s_q.cap_data[2]};
          3'h5: rdv = {16'h0, s_q.cap_data[3]};
          3'h6: rdv = 32'h0;
          3'h7: rdv = 32'h0;
        endcase
      end
      default:
      begin
        rdv = 32'h0;
        err = 1'b1;
      end
    endcase
    if (paddr[1:0] != 2'b00)
    begin
      rdv = 32'h0;
      err = 1'b1;
    end
    // pready high for exactly the cycle after setup
    s_d.pready = setup;
    if (setup)
    begin
      s_d.prdata  = pwrite ? 32'h0 : rdv;
      s_d.pslverr = err;
    end

    // interrupt requests; wait mode does not gate them
    s_d.cmd_irq = s_q.cmd_irq_en & cmd_done_flag;
    s_d.err_irq = (s_q.ers_f & s_q.ercfg[`FEECS_ERS_BIT])
                | (s_q.pgm_f & s_q.ercfg[`FEECS_PGM_BIT])
                | (s_q.pviol_f & s_q.ercfg[`FEECS_PVIOL_BIT])
                | (s_q.df_f & s_q.ercfg[`FEECS_DF_BIT])
                | (s_q.sf_f & s_q.ercfg[`FEECS_SF_BIT]);

    // stop waits for the running operation to finish
    s_d.stop_ack = stop_req & cmd_done_flag & ~ee_op_pending
                 & (s_q.phase == PH_RUN);

    // corrected read data, one cycle behind the request
    s_d.rvalid = rd_valid;
    s_d.rdata  = corr;
  end

  // one register for all state; async reset loads constants only
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      s_q         <= '0;
      s_q.phase   <= PH_INIT;
      s_q.ercfg   <= `FEECS_ERCFG_RST;
      s_q.sec     <= `FEECS_SEC_RST;
      s_q.prot    <= `FEECS_PROT_RST;
    end
    else
      s_q <= s_d;
  end

  assign prdata       = s_q.prdata;
  assign pready       = s_q.pready;
  assign pslverr      = s_q.pslverr;
  assign rd_out_valid = s_q.rvalid;
  assign rd_out_data  = s_q.rdata;
  assign stop_ack     = s_q.stop_ack;
  assign cmd_irq      = s_q.cmd_irq;
  assign err_irq      = s_q.err_irq;
endmodule : feecs_top

// file: feecs_checker.sv
// Purpose: port-level assertions for feecs_top
// Assumes: single pclk domain, presetn async active low
// Notes:   sees only top ports; attached by bind from tb_top
`timescale 1ns/1ns
module feecs_checker (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic [1:0]  rd_valid,
  input wire logic [1:0]  rd_out_valid,
  input wire logic        cmd_done_flag,
  input wire logic        ee_erase_fail,
  input wire logic        ee_program_fail,
  input wire logic        ee_wr_valid,
  input wire logic        ee_op_pending,
  input wire logic        stop_req,
  input wire logic        stop_ack,
  input wire logic        cmd_irq,
  input wire logic        err_irq
);
  // any event that may set an error flag or change an enable
  logic trig;
  assign trig = (rd_valid != 2'h0) || ee_erase_fail || ee_program_fail ||
                ee_wr_valid || (psel && penable && pwrite);
  // one domain, so clock and reset are given once
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  a_cmd_irq_cause:
    assert property (cmd_irq |-> $past(cmd_done_flag))
    else $error("cmd_irq high without done flag");
  a_err_irq_cause:
    assert property ($rose(err_irq) |->
      $past(trig) || $past(trig, 2) || $past(trig, 3))
    else $error("err_irq rose without a cause");
  a_stop_ack_gate:
    assert property ($past(presetn) |-> stop_ack ==
      $past(stop_req && cmd_done_flag && !ee_op_pending))
    else $error("stop_ack does not follow its conditions");
  a_rd_out_lag:
    assert property ($past(presetn) |-> rd_out_valid == $past(rd_valid))
    else $error("rd_out_valid not one cycle after rd_valid");
  a_apb_one_wait:
    assert property (psel && !penable |=> pready)
    else $error("pready missing after setup");
  a_pready_pulse:
    assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  a_misalign_err:
    assert property (psel && !penable && paddr[1:0] != 2'h0 |=> pslverr)
    else $error("misaligned access not refused");
  a_fcfg_reserved:
    assert property (pready && !pwrite && paddr == 12'h004 |->
      (prdata & 32'hffffff6c) == 32'h0)
    else $error("flash_config reserved bits not zero");
  a_ercfg_bit5:
    assert property (pready && !pwrite && paddr == 12'h008 |->
      (prdata & 32'hffffff20) == 32'h0)
    else $error("error config bit 5 not zero");
  c_stop: cover property (stop_ack);
  c_err: cover property ($rose(err_irq));
  c_slverr: cover property (pready && pslverr);
endmodule : feecs_checker

// file: tb_top.sv
// Purpose: self-checking bench for feecs_top over apb
// Assumes: one wait state apb slave, inputs driven on rising edge
// Notes:   expectations built from the register constants
`timescale 1ns/1ns
`include "feecs_regs.svh"
module tb_top;
  import feecs_pkg::*;
  logic             pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [11:0]      paddr;
  logic [31:0]      pwdata, prdata, rdv;
  logic [3:0]       pstrb;
  logic [7:0]       nvm_sec_byte;
  logic [2:0]       nvm_prot_init, cur;
  logic [1:0]       rd_valid, rd_prog, rd_out_valid;
  logic [1:0][22:0] rd_addr;
  logic [1:0][63:0] rd_data, rd_out_data;
  logic [1:0][7:0]  rd_par;
  logic             cmd_done_flag, mem_controller_busy, ee_erase_fail;
  logic             ee_program_fail, ee_wr_valid, ee_wr_in_ee_part;
  logic             ee_wr_in_prot_area, tag_inc, tag_dec, tag_clr;
  logic             ee_op_pending, stop_req, stop_ack, cmd_irq, err_irq;
  logic             rerr;
  int               err_count, checks;
  logic [7:0]       evx [5] = '{8'h80, 8'h40, 8'h10, 8'h00, 8'h80};
  feecs_top feecs_top_inst (.*);
  // free running 100 MHz clock
  initial
  begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  task automatic close_out;
    begin
      $display("checks %0d mismatches %0d", checks, err_count);
      if (err_count == 0 && checks > 0)
        $display("ALL TESTS PASSED");
      else
        $display("TESTS FAILED");
      $finish;
    end
  endtask : close_out
  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    begin
      checks++;
      if (g !== e)
      begin
        err_count++;
        $display("Error %s expected %h seen %h", nm, e, g);
      end
    end
  endtask : chk
  task automatic tk(input int n);
    repeat (n) @(posedge pclk);
  endtask : tk
  // setup, then hold the access until pready is sampled high
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    int n;
    begin
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do
      begin
        @(posedge pclk);
        n++;
      end
      while (pready !== 1'b1 && n < 20);
      if (n >= 20)
      begin
        err_count++;
        $display("Error pready expected 1 seen 0");
      end
      rdv = prdata;
      rerr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
    end
  endtask : apb
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr
  task automatic rd(input logic [11:0] a, input logic [31:0] e,
                    input string nm);
    begin
      apb(1'b0, a, 32'h0);
      chk(nm, e, rdv);
    end
  endtask : rd
  // one-cycle read on the chosen ports, parity all zero
  task automatic rd_go(input logic p, input logic [1:0] v,
                       input logic [63:0] d0, input logic [63:0] d1);
    begin
      rd_valid <= v;
      rd_prog <= {p, p};
      rd_data <= {d1, d0};
      tk(1);
      rd_valid <= 2'h0;
      tk(1);
    end
  endtask : rd_go
  // watchdog, well beyond the few hundred cycles the tests need
  initial
  begin
    #200000;
    err_count++;
    close_out();
  end
  initial
  begin
    {psel, penable, pwrite, paddr, pwdata, rd_valid, rd_prog} = '0;
    {rd_data, rd_par, cmd_done_flag, mem_controller_busy} = '0;
    {ee_erase_fail, ee_program_fail, ee_wr_valid, ee_wr_in_ee_part} = '0;
    {ee_wr_in_prot_area, tag_inc, tag_dec, tag_clr} = '0;
    {ee_op_pending, stop_req, err_count, checks} = '0;
    pstrb = 4'hf;
    nvm_sec_byte = 8'ha6;
    nvm_prot_init = 3'h1;
    rd_addr = {23'h54321, 23'h1a2b3};
    presetn = 1'b0;
    tk(2);
    presetn <= 1'b1;
    tk(2);
    rd(`FEECS_OFF_SEC, 32'ha6, "security_reg");
    rd(`FEECS_OFF_FCFG, 32'h0, "flash_config");
    rd(`FEECS_OFF_ERCFG, 32'h0, "error_cfg");
    wr(`FEECS_OFF_FCFG, 32'hff);
    rd(`FEECS_OFF_FCFG, 32'h93, "flash_config");
    wr(`FEECS_OFF_ERCFG, 32'hff);
    rd(`FEECS_OFF_ERCFG, 32'hdf, "error_cfg");
    wr(`FEECS_OFF_SEC, 32'h0);
    rd(`FEECS_OFF_SEC, 32'ha6, "security_reg");
    rd(12'h100, 32'h0, "unmapped");
    chk("pslverr", 32'h1, 32'(rerr));
    $display("test registers done");
    // every code from the current scenario; only tightening sticks
    cur = 3'h1;
    for (int r = 0; r < 8; r++)
    begin
      wr(`FEECS_OFF_PROT, 32'(r));
      if (`FEECS_PROT_ALLOW >> (8 * cur + r) & 64'h1)
        cur = 3'(r);
      rd(`FEECS_OFF_PROT, 32'(cur), "protection");
    end
    $display("test protection done");
    wr(`FEECS_OFF_FCFG, 32'h80);
    tk(2);
    chk("cmd_irq", 32'h0, 32'(cmd_irq));
    cmd_done_flag <= 1'b1;
    tk(3);
    chk("cmd_irq", 32'h1, 32'(cmd_irq));
    rd(`FEECS_OFF_FLASH_STATUS_REG, 32'h82, "flash_status");
    $display("test command irq done");
    // ignored single fault on a data word, then real ones on both ports
    wr(`FEECS_OFF_ERCFG, 32'h03);
    wr(`FEECS_OFF_FCFG, 32'h10);
    rd_go(1'b0, 2'h1, 64'h1, 64'h0);
    chk("corrected", 32'h0, rd_out_data[0][31:0]);
    rd(`FEECS_OFF_ERSTAT, 32'h0, "error_status");
    wr(`FEECS_OFF_FCFG, 32'h0);
    rd_go(1'b1, 2'h3, 64'h1, 64'h3);
    chk("corrected", 32'h0, rd_out_data[0][31:0]);
    rd(`FEECS_OFF_ERSTAT, 32'h03, "error_status");
    chk("err_irq", 32'h1, 32'(err_irq));
    wr(`FEECS_OFF_ECCIX, 32'h0);
    rd(`FEECS_OFF_ECCR, 32'h0085, "ecc_results");
    wr(`FEECS_OFF_ECCIX, 32'h1);
    rd(`FEECS_OFF_ECCR, 32'h4321, "ecc_results");
    rd_go(1'b1, 2'h1, 64'h10, 64'h0);
    rd(`FEECS_OFF_ECCR, 32'h4321, "ecc_results");
    wr(`FEECS_OFF_ERSTAT, 32'hff);
    wr(`FEECS_OFF_FCFG, 32'h03);
    rd_go(1'b1, 2'h1, 64'h0, 64'h0);
    rd(`FEECS_OFF_ERSTAT, 32'h03, "error_status");
    rd(`FEECS_OFF_ECCR, 32'h4321, "ecc_results");
    rd(`FEECS_OFF_FCFG, 32'h03, "flash_config");
    wr(`FEECS_OFF_FCFG, 32'h0);
    wr(`FEECS_OFF_ERSTAT, 32'hff);
    // both ports single: cpu port wins the capture
    rd_go(1'b1, 2'h3, 64'h10, 64'h10);
    rd(`FEECS_OFF_ECCR, 32'ha2b3, "ecc_results");
    wr(`FEECS_OFF_ERSTAT, 32'hff);
    // forced double hides a real single from the capture
    wr(`FEECS_OFF_FCFG, 32'h02);
    rd_go(1'b1, 2'h2, 64'h0, 64'h10);
    rd(`FEECS_OFF_ERSTAT, 32'h03, "error_status");
    rd(`FEECS_OFF_ECCR, 32'ha2b3, "ecc_results");
    wr(`FEECS_OFF_FCFG, 32'h0);
    wr(`FEECS_OFF_ERSTAT, 32'hff);
    $display("test ecc done");
    // erase, program, protected and user writes, then erase masked
    wr(`FEECS_OFF_ERCFG, 32'hd0);
    for (int k = 0; k < 5; k++)
    begin
      if (k == 4)
        wr(`FEECS_OFF_ERCFG, 32'h0);
      ee_erase_fail <= (k == 0 || k == 4);
      ee_program_fail <= (k == 1);
      ee_wr_valid <= (k == 2 || k == 3);
      ee_wr_in_ee_part <= (k == 2);
      ee_wr_in_prot_area <= 1'b1;
      tk(1);
      {ee_erase_fail, ee_program_fail, ee_wr_valid} <= 3'h0;
      tk(3);
      chk("err_irq", 32'(k < 3), 32'(err_irq));
      rd(`FEECS_OFF_ERSTAT, 32'(evx[k]), "error_status");
      wr(`FEECS_OFF_ERSTAT, 32'hff);
    end
    $display("test emulation errors done");
    tag_inc <= 1'b1;
    tk(3);
    tag_inc <= 1'b0;
    tag_dec <= 1'b1;
    tk(1);
    tag_dec <= 1'b0;
    wr(`FEECS_OFF_TAG, 32'hff);
    rd(`FEECS_OFF_TAG, 32'h2, "pending_words");
    rd(`FEECS_OFF_FLASH_STATUS_REG, 32'h80, "flash_status");
    tag_clr <= 1'b1;
    tk(1);
    tag_clr <= 1'b0;
    mem_controller_busy <= 1'b1;
    rd(`FEECS_OFF_FLASH_STATUS_REG, 32'h81, "flash_status");
    $display("test tag counter done");
    cmd_done_flag <= 1'b0;
    stop_req <= 1'b1;
    tk(3);
    chk("stop_ack", 32'h0, 32'(stop_ack));
    cmd_done_flag <= 1'b1;
    ee_op_pending <= 1'b1;
    tk(3);
    chk("stop_ack", 32'h0, 32'(stop_ack));
    ee_op_pending <= 1'b0;
    tk(3);
    chk("stop_ack", 32'h1, 32'(stop_ack));
    $display("test stop done");
    close_out();
  end
endmodule : tb_top
bind feecs_top feecs_checker feecs_checker_inst (.*);
